/* File: hw/tps_timer_prescaler.sv */
// Timer prescaler and external count synchroniser with the timer count register.
// Assumes phase strobes and register write strobes are one-cycle pulses on clk.
module tps_timer_prescaler
  import tps_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic ph2,
  input wire logic ph4,
  input wire logic instr_end,
  input wire logic count_pin,
  input wire logic cmp_out,
  input wire logic reg_wr,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic option_wr,
  input wire logic dir_wr,
  input wire logic watchdog_clear_instruction,
  output logic [7:0] timer_count_register,
  output logic [7:0] comparator_control_register,
  output logic [7:0] option_config,
  output logic [3:0] pin_direction,
  output logic watchdog_tick,
  output logic watchdog_clr
);
  ////////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [7:0] timer;
    logic [7:0] cmp;
    logic [7:0] opt;
    logic [3:0] dir;
    logic [7:0] pre;
    logic src_ff;
    logic samp2;
    logic samp4;
    logic [1:0] inhibit;
    logic wd_tick;
    logic wd_clr;
  } tps_state_t;

  tps_state_t st_ff;
  tps_state_t nxt_st;
  logic raw_in;
  logic src_edge;
  logic tmr_assigned;
  logic tap;
  logic pre_out;
  logic timer_wr;
  logic inc;

  ////////////////////////////////////////////////////////////////////////////////
  assign tmr_assigned = ~st_ff.opt[TPS_ASSIGN_BIT];
  assign raw_in = (st_ff.cmp[TPS_CMP_PIN_SEL_BIT] ? count_pin : cmp_out) ^ st_ff.opt[TPS_EDGE_BIT];
  assign src_edge = raw_in & ~st_ff.src_ff;
  assign timer_wr = reg_wr && reg_addr == TPS_ADDR_TIMER;

  tps_ratio_sel u_sel (
    .stages(st_ff.pre),
    .ratio(st_ff.opt[TPS_RATIO_LSB +: 3]),
    .tap(tap)
  );

  // The prescaler is a synchronous model of the ripple chain; its top stage stays symmetric.
  assign pre_out = tmr_assigned ? tap : raw_in;
  assign inc = st_ff.opt[TPS_SRC_BIT] ? (ph4 && st_ff.samp2 && !st_ff.samp4)
    : instr_end;

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.wd_tick = 1'b0;
    nxt_st.wd_clr = 1'b0;
    nxt_st.src_ff = raw_in;
    if (src_edge && (tmr_assigned ? st_ff.opt[TPS_SRC_BIT] : 1'b0))
    begin
      nxt_st.pre = st_ff.pre + 8'h01;
    end
    if (!tmr_assigned && instr_end)
    begin
      nxt_st.pre = st_ff.pre + 8'h01;
      nxt_st.wd_tick = (st_ff.pre[st_ff.opt[2:0]] && !nxt_st.pre[st_ff.opt[2:0]]);
    end
    if (ph2)
    begin
      nxt_st.samp2 = pre_out;
    end
    if (ph4)
    begin
      nxt_st.samp4 = st_ff.samp2;
    end
    if (instr_end && st_ff.inhibit != 2'h0)
    begin
      nxt_st.inhibit = st_ff.inhibit - 2'h1;
    end
    if (inc && st_ff.inhibit == 2'h0)
    begin
      nxt_st.timer = st_ff.timer + 8'h01;
    end
    if (timer_wr)
    begin
      nxt_st.timer = reg_wdata;
      nxt_st.inhibit = TPS_INHIBIT_CYCLES;
      if (tmr_assigned)
      begin
        nxt_st.pre = TPS_PRESCALE_RESET;
      end
    end
    if (reg_wr && reg_addr == TPS_ADDR_CMP)
    begin
      nxt_st.cmp = {st_ff.cmp[7], reg_wdata[6:0]};
    end
    if (option_wr)
    begin
      nxt_st.opt = reg_wdata;
    end
    if (dir_wr)
    begin
      nxt_st.dir = reg_wdata[3:0];
    end
    if (watchdog_clear_instruction)
    begin
      nxt_st.wd_clr = 1'b1;
      if (!tmr_assigned)
      begin
        nxt_st.pre = TPS_PRESCALE_RESET;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      st_ff <= '0;
      st_ff.timer <= 8'h00;
      st_ff.cmp <= TPS_CMP_RESET;
      st_ff.opt <= TPS_OPTION_RESET;
      st_ff.dir <= TPS_DIR_RESET;
      st_ff.pre <= TPS_PRESCALE_RESET;
    end
    else if (ce)
    begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  assign timer_count_register = st_ff.timer;
  assign comparator_control_register = {cmp_out, st_ff.cmp[6:0]};
  assign option_config = st_ff.opt;
  // The prescaler value is deliberately absent from the outputs.
  assign pin_direction = st_ff.opt[TPS_SRC_BIT] ? (st_ff.dir | 4'h4) : st_ff.dir;
  assign watchdog_tick = st_ff.wd_tick;
  assign watchdog_clr = st_ff.wd_clr;

  ////////////////////////////////////////////////////////////////////////////////
  a_reset_clears_pre: assert property (@(posedge clk) !rstn |=> st_ff.pre == 8'h00)
    else $error("prescaler not cleared by reset");
  a_wr_clears_pre: assert property (@(posedge clk) disable iff (!rstn)
    ce && timer_wr && tmr_assigned |=> st_ff.pre == 8'h00)
    else $error("timer write did not clear prescaler");
  a_wdclr_clears_pre: assert property (@(posedge clk) disable iff (!rstn)
    ce && watchdog_clear_instruction && !tmr_assigned && !timer_wr |=> st_ff.pre == 8'h00)
    else $error("watchdog clear did not clear prescaler");
  a_inhibit_after_wr: assert property (@(posedge clk) disable iff (!rstn)
    ce && timer_wr |=> st_ff.inhibit == 2'h2 && timer_count_register == $past(reg_wdata))
    else $error("write did not arm increment inhibit");
  a_no_inc_inhibit: assert property (@(posedge clk) disable iff (!rstn)
    ce && !timer_wr && st_ff.inhibit != 2'h0 |=> st_ff.timer == $past(st_ff.timer))
    else $error("timer moved while inhibited");
  a_opt_written: assert property (@(posedge clk) disable iff (!rstn)
    ce && option_wr |=> option_config == $past(reg_wdata))
    else $error("option write lost");
  a_dir_override: assert property (@(posedge clk) disable iff (!rstn)
    st_ff.opt[TPS_SRC_BIT] |-> pin_direction[TPS_COUNT_PIN])
    else $error("count pin direction not overridden");
  a_sample_ph2: assert property (@(posedge clk) disable iff (!rstn)
    ce && ph2 |=> st_ff.samp2 == $past(pre_out))
    else $error("phase two sample missed");
  c_timer_write: cover property (@(posedge clk) disable iff (!rstn) ce && timer_wr);
  c_wd_assigned: cover property (@(posedge clk) disable iff (!rstn) !tmr_assigned && watchdog_tick);
  c_ext_inc: cover property (@(posedge clk) disable iff (!rstn) st_ff.opt[TPS_SRC_BIT] && inc);
  c_wd_clear: cover property (@(posedge clk) disable iff (!rstn) !tmr_assigned && watchdog_clear_instruction);
endmodule : tps_timer_prescaler

/* File: include/tps_pkg.sv */
// Constants shared by the timer prescaler and external count synchroniser.
// Assumes one core clock with phase strobes supplied by the instruction sequencer.
// Behaviour
// - External count is sampled on phase two and phase four; no prescaler passes through.
// - With prescaler for the timer, the input is divided by a symmetric ripple count.
// - The timer increments on each instruction end, or with count source select set, only after the synchronised prescaler output is seen.
// - One 8-bit counter serves the timer or the watchdog, never both.
// - Option bits three to zero select assignment and division ratio.
// - Any timer count write clears the prescaler while it serves the timer.
// - Watchdog clear instruction clears the prescaler while it serves the watchdog.
// - The prescaler counter has no software read or write path.
// - Any reset clears the prescaler counter to zero.
// - The assignment may change at any time without halt or reset.
// - A set count source select overrides the count pin direction control.
// - Assignment bit clear routes to the timer, set routes to the watchdog.
// - For the timer, the ratio field selects 1:2 to 1:256 in powers of two.
// - A timer count write inhibits increments for the next two instruction cycles.
package tps_pkg;
  localparam logic [2:0] TPS_ADDR_TIMER = 3'h1;
  localparam logic [2:0] TPS_ADDR_CMP = 3'h7;
  localparam logic [7:0] TPS_OPTION_RESET = 8'hff;
  localparam logic [7:0] TPS_CMP_RESET = 8'hff;
  localparam logic [3:0] TPS_DIR_RESET = 4'hf;
  localparam int TPS_RATIO_LSB = 0;
  localparam int TPS_ASSIGN_BIT = 3;
  localparam int TPS_EDGE_BIT = 4;
  localparam int TPS_SRC_BIT = 5;
  localparam int TPS_CMP_PIN_SEL_BIT = 4;
  localparam int TPS_CMP_OUTEN_BIT = 6;
  localparam int TPS_COUNT_PIN = 2;
  localparam logic [1:0] TPS_INHIBIT_CYCLES = 2'h2;
  localparam logic [7:0] TPS_PRESCALE_RESET = 8'h00;
endpackage : tps_pkg

/* File: hw/tps_ratio_sel.sv */
// Selects the prescaler tap for the programmed ratio.
// Assumes the counter bits are the ripple stages, stage n dividing by 2^(n+1).
module tps_ratio_sel
  import tps_pkg::*;
(
  input wire logic [7:0] stages,
  input wire logic [2:0] ratio,
  output logic tap
);
  assign tap = stages[ratio];
endmodule : tps_ratio_sel

/* File: tb/tps_count_src.sv */
// Model of the external count source: the count pin and the comparator output.
// Assumes the bench calls pulses from its main sequence; times count clk cycles.
module tps_count_src (
  input wire logic clk,
  output logic count_pin,
  output logic cmp_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    count_pin = 1'b0;
    cmp_out = 1'b0;
  end
  // Both levels last half cycles, so the widths and the period stay legal for the caller.
  // Both sources idle low, so switching between them makes no false rising edge.
  task automatic pulses(input int n, input int half, input bit use_cmp);
    repeat (2 * n)
    begin
      repeat (half) @(negedge clk);
      if (use_cmp)
        cmp_out = ~cmp_out;
      else
        count_pin = ~count_pin;
    end
  endtask : pulses
endmodule : tps_count_src

/* File: tb/timer_prescaler_ext_clock_sync_tb_top.sv */
// Self-checking bench for the timer prescaler block.
// Assumes the bench makes the phase strobes itself, one instruction every four clocks.
module timer_prescaler_ext_clock_sync_tb_top import tps_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rstn, ce, reg_wr, option_wr, dir_wr, wdc, count_pin, cmp_out, tick, wclr;
  logic [2:0] reg_addr;
  logic [7:0] wdata, tmr, cmp, opt;
  logic [3:0] dir;
  logic [1:0] q;
  int miscompares, samples_checked, ticks, clrs;
  tps_timer_prescaler uut (.clk(clk), .rstn(rstn), .ce(ce), .ph2(q == 2'h1), .ph4(q == 2'h3),
    .instr_end(q == 2'h3), .count_pin(count_pin), .cmp_out(cmp_out), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(wdata), .option_wr(option_wr), .dir_wr(dir_wr),
    .watchdog_clear_instruction(wdc), .timer_count_register(tmr), .comparator_control_register(cmp),
    .option_config(opt), .pin_direction(dir), .watchdog_tick(tick), .watchdog_clr(wclr));
  tps_count_src src (.clk(clk), .count_pin(count_pin), .cmp_out(cmp_out));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(negedge clk) q <= q + 2'h1;
  always @(posedge clk)
  begin
    if (tick === 1'b1) ticks++;
    if (wclr === 1'b1) clrs++;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Returns one edge before an instruction starts, so the next strobe lands on its first clock.
  task automatic align;
    do @(negedge clk); while (q !== 2'h2);
  endtask : align
  task automatic strobe(input int kind, input logic [2:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    wdata = d;
    {reg_wr, option_wr, dir_wr, wdc} = 4'h8 >> kind;
    @(negedge clk);
    {reg_wr, option_wr, dir_wr, wdc} = 4'h0;
  endtask : strobe
  task automatic report_and_stop;
    if (miscompares == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop
  initial
  begin
    #2000000;
    miscompares++;
    report_and_stop();
  end
  initial
  begin
    rstn = 1'b0;
    ce = 1'b1;
    {reg_wr, option_wr, dir_wr, wdc} = 4'h0;
    q = 2'h0;
    reg_addr = 3'h0;
    wdata = 8'h00;
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    chk(tmr, 8'h00);
    chk(opt, TPS_OPTION_RESET);
    chk({1'b0, cmp[6:0]}, {1'b0, TPS_CMP_RESET[6:0]});
    chk({4'h0, dir}, {4'h0, TPS_DIR_RESET});
    chk({7'h0, cmp[7]}, {7'h0, cmp_out});
    strobe(2, 3'h0, 8'h00);
    strobe(1, 3'h0, 8'h08);
    chk({4'h0, dir}, 8'h00);
    strobe(1, 3'h0, 8'h28);
    chk({4'h0, dir}, 8'h04);
    strobe(1, 3'h0, 8'h08);
    align();
    strobe(0, TPS_ADDR_TIMER, 8'hfe);
    repeat (7) @(negedge clk);
    chk(tmr, 8'hfe);
    repeat (4) @(negedge clk);
    chk(tmr, 8'hff);
    repeat (4) @(negedge clk);
    chk(tmr, 8'h00);
    align();
    clrs = 0;
    strobe(3, 3'h0, 8'h00);
    @(negedge clk);
    ticks = 0;
    repeat (64) @(negedge clk);
    chk(8'(ticks), 8'h08);
    chk(8'(clrs), 8'h01);
    strobe(1, 3'h0, 8'h28);
    align();
    strobe(0, TPS_ADDR_TIMER, 8'h00);
    src.pulses(5, 12, 1'b0);
    repeat (12) @(negedge clk);
    chk(tmr, 8'h05);
    strobe(0, TPS_ADDR_CMP, 8'h6f);
    src.pulses(3, 12, 1'b1);
    repeat (12) @(negedge clk);
    chk(tmr, 8'h08);
    strobe(0, TPS_ADDR_CMP, 8'h7f);
    strobe(3, 3'h0, 8'h00);
    // Each ratio gets exactly one tap period, so one step proves the division and the clear.
    for (int r = 0; r < 8; r++)
    begin
      strobe(1, 3'h0, 8'h20 | 8'(r));
      align();
      strobe(0, TPS_ADDR_TIMER, 8'h00);
      src.pulses(2 << r, 8, 1'b0);
      repeat (12) @(negedge clk);
      chk(tmr, 8'h01);
    end
    strobe(3, 3'h0, 8'h00);
    strobe(0, TPS_ADDR_TIMER, 8'h00);
    strobe(1, 3'h0, 8'h0f);
    strobe(3, 3'h0, 8'h00);
    strobe(1, 3'h0, 8'h08);
    chk(opt, 8'h08);
    report_and_stop();
  end
endmodule : timer_prescaler_ext_clock_sync_tb_top
